// >>> inc/sodt_pkg.sv
// constants, types and register map of the second dependency term
// assumes one 100 MHz clock and an ahb-lite master reaching the map
//
// What this block does
// R01 - 27h bits 0-3 make output depend on monitors 1-4 primary fault
// R02 - 27h bits 4-5 cover monitors 5-6; four-input software writes 0
// R03 - 27h bits 6-7 make output depend on watchdogs 1 and 2
// R04 - 28h bits 0-3 make output depend on monitors 1-4 secondary fault
// R05 - 28h bits 4-5 cover secondary of monitors 5-6; four-input writes 0
// R06 - 28h bits 6-7 make output depend on logic inputs 1 and 2
// R07 - 29h bits 0-1 make output depend on logic inputs 3 and 4
// R08 - 29h bits 2-3 cover outputs 1-2, six-input only, else written 0
// R09 - 29h bits 4-7 cover outputs 3,4,6,7 or 1,2,4,5 by variant
// R10 - 3Bh bit 4 covers output eight, six-input only, else written 0
// R11 - 40h bit 4 set breaks the term while manual reset is low
// R12 - a mask bit of 0 makes the output ignore that signal
// R13 - output deasserts when either product term is 1
// R14 - this mask set drives only output five or output three
// R15 - term is 1 only when all masked signals are fault free
// R16 - each mask has a nonvolatile copy loaded into the working register
package sodt_pkg;

    localparam int          SODT_NUM_REGS    = 5;
    localparam int          SODT_SLOT_W      = 3;
    // register indices; byte address is four times the index
    localparam logic [15:0] SODT_IDX_PRIM_WD = 16'h0027;
    localparam logic [15:0] SODT_IDX_SEC_GPI = 16'h0028;
    localparam logic [15:0] SODT_IDX_GPI_OUT = 16'h0029;
    localparam logic [15:0] SODT_IDX_OUT8    = 16'h003b;
    localparam logic [15:0] SODT_IDX_MAN_RST = 16'h0040;
    localparam logic [15:0] SODT_IDX_NVM     = 16'h8000;
    localparam logic [15:0] SODT_IDX_CTRL    = 16'h0070;
    localparam logic [15:0] SODT_IDX_STAT    = 16'h0071;
    // field positions
    localparam int          SODT_WD_LSB      = 6;
    localparam int          SODT_GPI_LO_LSB  = 6;
    localparam int          SODT_OUT12_LSB   = 2;
    localparam int          SODT_OTH_LSB     = 4;
    localparam int          SODT_OUT8_BIT    = 4;
    localparam int          SODT_MAN_RST_BIT = 4;
    localparam int          SODT_RELOAD_BIT  = 0;
    localparam int          SODT_BUSY_BIT    = 0;
    localparam int          SODT_TERM_BIT    = 1;
    localparam int          SODT_OUTPUT_BIT  = 2;
    // which outputs 29h bits 4-7 select, per variant
    localparam int          SODT_MAP_SIX [4] = '{3, 4, 6, 7};
    localparam int          SODT_MAP_FOUR[4] = '{1, 2, 4, 5};
    localparam logic [7:0]  SODT_MASK_RST    = 8'h00;
    // load walk: one cycle per slot plus one for the first read
    localparam logic [2:0]  SODT_LOAD_LAST   = 3'h5;

    typedef enum logic {
        SODT_LOAD_IDLE = 1'b0,
        SODT_LOAD_RUN  = 1'b1
    } sodt_load_st_t;

    typedef struct packed {
        logic [5:0] prim;
        logic [5:0] sec;
        logic [1:0] wd;
        logic [3:0] gpi;
        logic       manual_reset_n;
    } sodt_pins_t;

    localparam sodt_pins_t SODT_PINS_RST = '{default: '0,
                                             manual_reset_n: 1'b1};

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] idx;
    } sodt_req_t;

endpackage

// >>> logic/sodt_cfg_nvm.sv
// nonvolatile copy of the dependency masks, one word per slot
// assumes one clock; contents survive reset, read data are registered
`timescale 1ns/1ns
module sodt_cfg_nvm #(
    parameter int DEPTH = 5,
    parameter int WIDTH = 8,
    parameter int AW    = 3
) (
    // clock
    input  wire logic             mclk_in,
    // write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // two read ports
    input  wire logic [AW-1:0]    rd_a_addr_in,
    output logic      [WIDTH-1:0] rd_a_data_out,
    input  wire logic [AW-1:0]    rd_b_addr_in,
    output logic      [WIDTH-1:0] rd_b_data_out
);

    // blank part comes up erased; reset leaves the contents alone
    logic [WIDTH-1:0] mem_q [DEPTH] = '{default: '0};

    always_ff @(posedge mclk_in)
    begin
        if (wr_en_in)
            mem_q[wr_addr_in] <= wr_data_in;
    end

    // write-first so a read right after a write sees the new word
    always_ff @(posedge mclk_in)
    begin
        if (wr_en_in && wr_addr_in == rd_a_addr_in)
            rd_a_data_out <= wr_data_in;
        else
            rd_a_data_out <= mem_q[rd_a_addr_in];
        if (wr_en_in && wr_addr_in == rd_b_addr_in)
            rd_b_data_out <= wr_data_in;
        else
            rd_b_data_out <= mem_q[rd_b_addr_in];
    end

endmodule // sodt_cfg_nvm

// >>> logic/sodt_term_b.sv
// second dependency product term of one sequencing output
// assumes ahb-lite master with one slave, fault pins asynchronous
`timescale 1ns/1ns
module sodt_term_b
    import sodt_pkg::*;
#(
    parameter bit SIX_INPUT = 1'b1
) (
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    // ahb-lite slave
    input  wire logic              hsel_in,
    input  wire logic [17:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic              hready_in,
    input  wire logic [31:0]       hwdata_in,
    output logic      [31:0]       hrdata_out,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    // fault and logic pins, asynchronous
    input  wire sodt_pkg::sodt_pins_t pins_in,
    // other programmable outputs and first term, same clock
    input  wire logic [8:1]        seq_outputs_in,
    input  wire logic              term_a_in,
    // result
    output logic                   term_b_out,
    output logic                   seq_output_five_out
);

    import sodt_pkg::*;

    function automatic logic [3:0] slot_of(input logic [15:0] idx);
        case (idx)
            SODT_IDX_PRIM_WD: slot_of = 4'h8;
            SODT_IDX_SEC_GPI: slot_of = 4'h9;
            SODT_IDX_GPI_OUT: slot_of = 4'ha;
            SODT_IDX_OUT8:    slot_of = 4'hb;
            SODT_IDX_MAN_RST: slot_of = 4'hc;
            default:          slot_of = 4'h0;
        endcase
    endfunction

    sodt_pins_t       pins_s1_q;
    sodt_pins_t       pins_s2_q;
    sodt_req_t        req_q;
    sodt_load_st_t    load_st_q;
    logic [2:0]       load_cnt_q;
    logic [7:0]       work_q [SODT_NUM_REGS];
    logic [31:0]      rd_q;
    logic [31:0]      rd_d;
    logic             rd_nvm_q;
    logic             term_b_q;
    logic             out_q;
    logic             take;
    logic [15:0]      a_idx;
    logic [3:0]       a_work;
    logic [3:0]       a_nvm;
    logic [3:0]       d_work;
    logic [3:0]       d_nvm;
    logic             wr_work;
    logic             wr_nvm;
    logic             reload;
    logic             load_busy;
    logic             load_wr;
    logic [7:0]       nvm_rd_a;
    logic [7:0]       nvm_rd_b;
    logic [3:0]       oth;
    logic             fault_hit;
    logic             term_b;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // pins pass two flops before any use
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pins_s1_q <= SODT_PINS_RST;
            pins_s2_q <= SODT_PINS_RST;
        end
        else
        begin
            pins_s1_q <= pins_in;
            pins_s2_q <= pins_s1_q;
        end
    end

    // bus address phase
    assign take   = hsel_in && hready_in && htrans_in[1];
    assign a_idx  = haddr_in[17:2];
    assign a_work = slot_of(a_idx);
    assign a_nvm  = a_idx[15] ? slot_of(a_idx - SODT_IDX_NVM) : 4'h0;
    assign d_work = slot_of(req_q.idx);
    assign d_nvm  = req_q.idx[15] ? slot_of(req_q.idx - SODT_IDX_NVM)
                                  : 4'h0;
    assign wr_work = req_q.wr && d_work[3];
    assign wr_nvm  = req_q.wr && d_nvm[3];
    assign reload  = req_q.wr && req_q.idx == SODT_IDX_CTRL
                     && hwdata_in[SODT_RELOAD_BIT];

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            req_q <= '0;
        else if (hready_in)
        begin
            req_q.wr  <= take && hwrite_in;
            req_q.rd  <= take && !hwrite_in;
            req_q.idx <= a_idx;
        end
    end

    // read data are fetched in the address phase
    always_comb
    begin
        rd_d = '0;
        if (a_work[3])
        begin
            if (wr_work && req_q.idx == a_idx)
                rd_d[7:0] = hwdata_in[7:0];
            else
                rd_d[7:0] = work_q[a_work[2:0]];
        end
        else if (a_idx == SODT_IDX_STAT)
        begin
            rd_d[SODT_BUSY_BIT]   = load_busy;
            rd_d[SODT_TERM_BIT]   = term_b_q;
            rd_d[SODT_OUTPUT_BIT] = out_q;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rd_q     <= '0;
            rd_nvm_q <= 1'b0;
        end
        else if (take && !hwrite_in)
        begin
            rd_q     <= rd_d;
            rd_nvm_q <= a_nvm[3];
        end
    end

    assign hrdata_out    = rd_nvm_q ? {24'h000000, nvm_rd_b} : rd_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    sodt_cfg_nvm #(
        .DEPTH (SODT_NUM_REGS),
        .WIDTH (8),
        .AW    (SODT_SLOT_W)
    ) u_nvm (
        .mclk_in       (mclk_in),
        .wr_en_in      (wr_nvm),
        .wr_addr_in    (d_nvm[2:0]),
        .wr_data_in    (hwdata_in[7:0]),
        .rd_a_addr_in  (load_cnt_q),
        .rd_a_data_out (nvm_rd_a),
        .rd_b_addr_in  (a_nvm[2:0]),
        .rd_b_data_out (nvm_rd_b)
    );

    // walk every slot from the copy into the working registers
    assign load_busy = load_st_q == SODT_LOAD_RUN;
    assign load_wr   = load_busy && load_cnt_q != 3'h0;

    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            load_st_q  <= SODT_LOAD_RUN;
            load_cnt_q <= 3'h0;
        end
        else
        begin
            case (load_st_q)
                SODT_LOAD_IDLE:
                begin
                    load_cnt_q <= 3'h0;
                    if (reload)
                        load_st_q <= SODT_LOAD_RUN;
                end
                SODT_LOAD_RUN:
                begin
                    if (load_cnt_q == SODT_LOAD_LAST)
                    begin
                        load_st_q  <= SODT_LOAD_IDLE;
                        load_cnt_q <= 3'h0;
                    end
                    else
                        load_cnt_q <= load_cnt_q + 3'h1;
                end
                default:
                begin
                    load_st_q  <= SODT_LOAD_IDLE;
                    load_cnt_q <= 3'h0;
                end
            endcase
        end
    end

    // working masks; a bus write wins over the load walk
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (int i = 0; i < SODT_NUM_REGS; i++)
                work_q[i] <= SODT_MASK_RST;
        end
        else
        begin
            for (int i = 0; i < SODT_NUM_REGS; i++)
            begin
                if (wr_work && d_work[2:0] == i[2:0])
                    work_q[i] <= hwdata_in[7:0];
                else if (load_wr && load_cnt_q - 3'h1 == i[2:0]) // R16
                    work_q[i] <= nvm_rd_a;
            end
        end
    end

    // 29h bits 4-7 pick other outputs by variant
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_oth
            assign oth[g] = SIX_INPUT ? seq_outputs_in[SODT_MAP_SIX[g]]
                                      : seq_outputs_in[SODT_MAP_FOUR[g]];
        end
    endgenerate

    // any masked signal in fault breaks the term
    always_comb
    begin
        fault_hit = 1'b0;
        fault_hit |= |(work_q[0][5:0] & pins_s2_q.prim); // R01 R02
        fault_hit |= |(work_q[0][7:SODT_WD_LSB] & pins_s2_q.wd); // R03
        fault_hit |= |(work_q[1][5:0] & pins_s2_q.sec); // R04 R05
        fault_hit |= |(work_q[1][7:SODT_GPI_LO_LSB]
                       & pins_s2_q.gpi[1:0]); // R06
        fault_hit |= |(work_q[2][1:0] & pins_s2_q.gpi[3:2]); // R07
        fault_hit |= |(work_q[2][3:SODT_OUT12_LSB]
                       & seq_outputs_in[2:1]); // R08
        fault_hit |= |(work_q[2][7:SODT_OTH_LSB] & oth); // R09
        fault_hit |= work_q[3][SODT_OUT8_BIT] && seq_outputs_in[8]; // R10
        fault_hit |= work_q[4][SODT_MAN_RST_BIT]
                     && !pins_s2_q.manual_reset_n; // R11
    end

    // zero mask bits drop out of the product
    assign term_b = !fault_hit; // R12 R15

    // held asserted until the masks are loaded
    always_ff @(posedge mclk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            term_b_q <= 1'b0;
            out_q    <= 1'b1;
        end
        else
        begin
            term_b_q <= term_b;
            out_q    <= load_busy || !(term_a_in || term_b); // R13
        end
    end

    assign term_b_out          = term_b_q;
    assign seq_output_five_out = out_q; // R14

    out_deassert_a: assert property ( // R13
        !load_busy |=> out_q == !($past(term_a_in) || $past(term_b)))
        else $error("output level does not follow the two terms");

    zero_mask_a: assert property ( // R12
        (work_q[0] == 8'h00 && work_q[1] == 8'h00 && work_q[2] == 8'h00
         && work_q[3] == 8'h00 && work_q[4] == 8'h00) |=> term_b_q)
        else $error("term low with every mask clear");

    man_rst_a: assert property ( // R11
        (work_q[4][SODT_MAN_RST_BIT] && !pins_s2_q.manual_reset_n)
         |-> ##1 !term_b_q)
        else $error("manual reset low did not break the term");

    wd_dep_a: assert property ( // R03
        |(work_q[0][7:SODT_WD_LSB] & pins_s2_q.wd) |=> !term_b_q)
        else $error("watchdog fault ignored");

    prim_dep_a: assert property ( // R01
        |(work_q[0][3:0] & pins_s2_q.prim[3:0]) |-> !term_b)
        else $error("primary fault ignored");

    sec_gpi_dep_a: assert property ( // R04
        (|(work_q[1][3:0] & pins_s2_q.sec[3:0])
         || |(work_q[2][1:0] & pins_s2_q.gpi[3:2])) |-> !term_b)
        else $error("secondary or logic input fault ignored");

    out_map_a: assert property ( // R09
        (work_q[2][SODT_OTH_LSB]
         && seq_outputs_in[SIX_INPUT ? 3 : 1]) |-> !term_b)
        else $error("other output dependency mapped wrongly");

    load_walk_a: assert property ( // R16
        (reload && !load_busy) |=> load_busy [*6] ##1 !load_busy)
        else $error("mask load walk has the wrong length");

    work_write_a: assert property ( // R16
        (wr_work && d_work[2:0] == 3'h0)
         |=> work_q[0] == $past(hwdata_in[7:0]))
        else $error("bus write lost in working mask");

    gpi_lo_dep_a: assert property ( // R06
        |(work_q[1][7:SODT_GPI_LO_LSB] & pins_s2_q.gpi[1:0]) |-> !term_b)
        else $error("logic input one or two fault ignored");

    oth_hi_dep_a: assert property ( // R09
        (work_q[2][SODT_OTH_LSB + 3]
         && seq_outputs_in[SIX_INPUT ? 7 : 5]) |-> !term_b)
        else $error("highest other output dependency mapped wrongly");

    man_rst_free_a: assert property ( // R12
        (!work_q[4][SODT_MAN_RST_BIT] && work_q[0] == 8'h00
         && work_q[1] == 8'h00 && work_q[2] == 8'h00
         && work_q[3] == 8'h00) |-> term_b)
        else $error("unmasked manual reset broke the term");

    work_load_a: assert property ( // R16
        (load_wr && load_cnt_q == 3'h1
         && !(wr_work && d_work[2:0] == 3'h0))
         |=> work_q[0] == $past(nvm_rd_a))
        else $error("first mask slot not loaded from the copy");

    busy_out_a: assert property ( // R16
        load_busy |=> out_q)
        else $error("output released during mask load");

    term_a_out_a: assert property ( // R13
        (term_a_in && !load_busy) |=> !out_q)
        else $error("first term high did not deassert output");

endmodule // sodt_term_b

// >>> testbench/sodt_pin_src.sv
// far-side model: supply faults, logic inputs, manual reset, other outputs
// assumes the bench hands it a fault vector; pins move after a rising edge
`timescale 1ns/1ns
module sodt_pin_src
    import sodt_pkg::*;
(
    // clock
    input  wire logic            mclk_in,
    // requested faults; slow adds one cycle of lag
    input  wire logic [26:0]     fault_in,
    input  wire logic            slow_in,
    // pins toward the device
    output sodt_pkg::sodt_pins_t pins_out,
    output logic      [8:1]      seq_out
);
    logic [26:0] lag_q = '0;
    logic [26:0] cur_q = '0;

    always_ff @(posedge mclk_in)
    begin
        lag_q <= fault_in;
        cur_q <= slow_in ? lag_q : fault_in;
    end

    // manual reset is active low, other outputs high while asserted
    assign pins_out = '{prim: cur_q[5:0], sec: cur_q[11:6], wd: cur_q[13:12],
                        gpi: cur_q[17:14], manual_reset_n: ~cur_q[18]};
    assign seq_out  = cur_q[26:19];
endmodule // sodt_pin_src

// >>> testbench/sodt_term_b_bench.sv
// self-checking bench for the second dependency term
// assumes zero-wait ahb-lite slave and the far-side pin model
`timescale 1ns/1ns
module sodt_term_b_bench;
    import sodt_pkg::*;

    logic        mclk_in    = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        hsel       = 1'b0;
    logic [17:0] haddr      = '0;
    logic [1:0]  htrans     = '0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = '0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [26:0] fault      = '0;
    logic        slow       = 1'b0;
    logic        term_a     = 1'b0;
    logic        term_b;
    logic        out_five;
    sodt_pins_t  pins;
    logic [8:1]  seq;
    int          miscompares = 0;
    int          cmp_count   = 0;
    logic [15:0] regs [5] = '{SODT_IDX_PRIM_WD, SODT_IDX_SEC_GPI,
                              SODT_IDX_GPI_OUT, SODT_IDX_OUT8,
                              SODT_IDX_MAN_RST};

    always #5 mclk_in = ~mclk_in;

    sodt_pin_src i_src (.mclk_in(mclk_in), .fault_in(fault), .slow_in(slow),
                        .pins_out(pins), .seq_out(seq));

    sodt_term_b #(.SIX_INPUT(1'b1)) i_dut (
        .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hready_in(hready), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .pins_in(pins), .seq_outputs_in(seq), .term_a_in(term_a),
        .term_b_out(term_b), .seq_output_five_out(out_five));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50; n++)
        begin
            @(posedge mclk_in);
            if (hready === 1'b1)
                break;
        end
        if (n == 50)
        begin
            miscompares++;
            conclude();
        end
    endtask

    task automatic bus(logic wr, logic [15:0] idx, logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge mclk_in);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wait_idle();
        logic [31:0] rd;
        for (int n = 0; n < 20; n++)
        begin
            bus(1'b0, SODT_IDX_STAT, 32'h0, rd);
            if (rd[SODT_BUSY_BIT] === 1'b0)
                return;
        end
        miscompares++;
        conclude();
    endtask

    // drive a fault pattern and first term, then judge term and output
    task automatic put(logic [26:0] fv, logic ta, logic et);
        @(posedge mclk_in);
        fault  <= fv;
        term_a <= ta;
        slow   <= ~slow;
        repeat (6) @(posedge mclk_in);
        chk(32'(term_b), 32'(et));
        chk(32'(out_five), 32'(!(ta || et)));
    endtask

    function automatic int fault_pos(int r, int b);
        case (r)
            0: return (b < 6) ? b : b + 6;
            1: return (b < 6) ? b + 6 : b + 8;
            2: return b + ((b < 2) ? 16 : (b < 6) ? 17 : 18);
            3: return (b == 4) ? 26 : -1;
            default: return (b == 4) ? 18 : -1;
        endcase
    endfunction

    task automatic t_reset();
        logic [31:0] rd;
        repeat (3) @(posedge mclk_in);
        chk(32'(out_five), 32'h1);
        chk(32'(term_b), 32'h0);
        chk(32'(hresp), 32'h0);
        sys_rst_in <= 1'b0;
        bus(1'b0, SODT_IDX_STAT, 32'h0, rd);
        chk(32'(rd[SODT_BUSY_BIT]), 32'h1);
        chk(32'(rd[SODT_OUTPUT_BIT]), 32'h1);
        wait_idle();
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        for (int r = 0; r < 5; r++)
        begin
            bus(1'b0, regs[r], 32'h0, rd);
            chk(rd, 32'h0);
            bus(1'b1, regs[r], 32'h50 | 32'(r), rd);
        end
        for (int r = 0; r < 5; r++)
        begin
            bus(1'b0, regs[r], 32'h0, rd);
            chk(rd, 32'h50 | 32'(r));
            bus(1'b1, regs[r], 32'h0, rd);
        end
        bus(1'b1, 16'h0031, 32'hff, rd);
        bus(1'b0, 16'h0031, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    task automatic t_bits();
        int          p;
        logic [31:0] rd;
        for (int r = 0; r < 5; r++)
            for (int b = 0; b < 8; b++)
            begin
                p = fault_pos(r, b);
                if (p >= 0)
                begin
                    bus(1'b1, regs[r], 32'h1 << b, rd);
                    put(~(27'h1 << p), 1'b0, 1'b1);
                    put(27'h1 << p, 1'b0, 1'b0);
                    bus(1'b1, regs[r], 32'h0, rd);
                end
            end
    endtask

    task automatic t_combine();
        logic [31:0] rd;
        put(27'h7ffffff, 1'b0, 1'b1);
        bus(1'b1, SODT_IDX_PRIM_WD, 32'h1, rd);
        put(27'h1, 1'b1, 1'b0);
        put(27'h0, 1'b1, 1'b1);
        put(27'h0, 1'b0, 1'b1);
        put(27'h1, 1'b0, 1'b0);
    endtask

    task automatic t_reload();
        logic [31:0] rd;
        bus(1'b1, SODT_IDX_NVM | SODT_IDX_PRIM_WD, 32'h5a, rd);
        bus(1'b1, SODT_IDX_PRIM_WD, 32'h0, rd);
        bus(1'b1, SODT_IDX_CTRL, 32'h1, rd);
        bus(1'b0, SODT_IDX_STAT, 32'h0, rd);
        chk(32'(rd[SODT_BUSY_BIT]), 32'h1);
        wait_idle();
        bus(1'b0, SODT_IDX_PRIM_WD, 32'h0, rd);
        chk(rd, 32'h5a);
        bus(1'b0, SODT_IDX_NVM | SODT_IDX_PRIM_WD, 32'h0, rd);
        chk(rd, 32'h5a);
        @(posedge mclk_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        wait_idle();
        bus(1'b0, SODT_IDX_PRIM_WD, 32'h0, rd);
        chk(rd, 32'h5a);
    endtask

    initial
    begin
        t_reset();
        t_regs();
        t_bits();
        t_combine();
        t_reload();
        conclude();
    end
endmodule // sodt_term_b_bench
